// file: rtl/eeprom_guard_params.svh
// Overview of operation
// - Guard register sits at block 000b, word address E2h.
// - Bit 2 enables guarding; when clear nothing is guarded.
// - Extent 00 upper quarter, 01 upper half, 10 upper 3/4, 11 all.
// - With guarding disabled the extent field has no effect at all.
// - Writes into guarded EEPROM locations are inhibited.
// - Reset leaves enable at 0 and extent at 00.
// - Freeze bit at config bit 1824; once set, three guard registers hold until the next reset.
// - While freeze bit is 0, all three guard registers are writable.
// - Random read returns the current guard register value.
// - Emulated EEPROM lives at block 011b, sixteen 16-byte pages.
// - Control byte LSB is direction: 1 read, 0 write; acked after it.
`ifndef EEPROM_GUARD_PARAMS_SVH
`define EEPROM_GUARD_PARAMS_SVH
`define CTRL_CODE       4'h1
`define BLK_REG         3'h0
`define BLK_EEPROM      3'h3
`define ADDR_CFG_GUARD  8'hE0
`define ADDR_NVM_GUARD  8'hE1
`define ADDR_GUARD      8'hE2
`define ADDR_FREEZE     8'hE4
`define FREEZE_BIT      0
`define GUARD_EN_BIT    2
`define GUARD_EXT_MSB   1
`define GUARD_EXT_LSB   0
`define GUARD_RESET     3'h0
`define SIBLING_RESET   8'h00
`define EEPROM_ERASED   8'hFF
`endif

// file: rtl/eeprom_guard_pkg.sv
package eeprom_guard_pkg;
  typedef logic [7:0] byte_t;
  typedef enum logic [2:0] {ST_IDLE, ST_CTRL, ST_WORD, ST_DATA, ST_READ, ST_IGNORE} xfer_state_t;
endpackage : eeprom_guard_pkg

// file: rtl/i2c_link_if.sv
`timescale 1ns/10ps
`default_nettype none
interface i2c_link_if;
  logic                   start;
  logic                   stop;
  logic                   rx_valid;
  eeprom_guard_pkg::byte_t rx_byte;
  logic                   tx_ack;
  logic                   ack_en;
  logic                   rd_mode;
  eeprom_guard_pkg::byte_t tx_data;
  modport phy  (output start, stop, rx_valid, rx_byte, tx_ack, input ack_en, rd_mode, tx_data);
  modport core (input start, stop, rx_valid, rx_byte, tx_ack, output ack_en, rd_mode, tx_data);
endinterface : i2c_link_if
`default_nettype wire

// file: rtl/i2c_target_phy.sv
`timescale 1ns/10ps
`default_nettype none
module i2c_target_phy (
  input  wire logic  i_clk,
  input  wire logic  i_rst_n,
  input  wire logic  i_scl,
  input  wire logic  i_sda,
  output logic       o_sda_oe,
  i2c_link_if.phy    lk
);
  logic [1:0] scl_sync_q;
  logic [1:0] sda_sync_q;
  logic       scl_d_q;
  logic       sda_d_q;
  logic       active_q;
  logic       first_q;
  logic [3:0] bit_cnt_q;
  logic [7:0] shift_q;
  logic [7:0] tx_sh_q;
  logic       scl_s;
  logic       sda_s;
  logic       scl_rise;
  logic       scl_fall;

  assign scl_s    = scl_sync_q[1];
  assign sda_s    = sda_sync_q[1];
  assign scl_rise = scl_s & ~scl_d_q;
  assign scl_fall = ~scl_s & scl_d_q;
  assign lk.start = scl_s & scl_d_q & sda_d_q & ~sda_s;
  assign lk.stop  = scl_s & scl_d_q & ~sda_d_q & sda_s;
  assign lk.rx_byte = shift_q;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      scl_sync_q <= 2'h3;
      sda_sync_q <= 2'h3;
      scl_d_q    <= 1'b1;
      sda_d_q    <= 1'b1;
    end else begin
      scl_sync_q <= {scl_sync_q[0], i_scl};
      sda_sync_q <= {sda_sync_q[0], i_sda};
      scl_d_q    <= scl_s;
      sda_d_q    <= sda_s;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      active_q    <= 1'b0;
      first_q     <= 1'b0;
      bit_cnt_q   <= 4'h0;
      shift_q     <= 8'h00;
      tx_sh_q     <= 8'h00;
      o_sda_oe    <= 1'b0;
      lk.rx_valid <= 1'b0;
      lk.tx_ack   <= 1'b0;
    end else begin
      lk.rx_valid <= 1'b0;
      lk.tx_ack   <= 1'b0;
      if (lk.start) begin
        active_q  <= 1'b1;
        first_q   <= 1'b1;
        bit_cnt_q <= 4'h0;
        o_sda_oe  <= 1'b0;
      end else if (lk.stop) begin
        active_q  <= 1'b0;
        o_sda_oe  <= 1'b0;
      end else if (active_q && scl_rise) begin
        if (bit_cnt_q < 4'h8) begin
          shift_q     <= {shift_q[6:0], sda_s};
          bit_cnt_q   <= bit_cnt_q + 4'h1;
          lk.rx_valid <= (bit_cnt_q == 4'h7) && !lk.rd_mode;
        end else begin
          bit_cnt_q <= 4'h9;
          // A not-acknowledge ends the read; the bus is left alone until the next start
          if (lk.rd_mode && !first_q && sda_s) begin
            active_q <= 1'b0;
          end
          lk.tx_ack <= lk.rd_mode && !first_q && !sda_s;
        end
      end else if (active_q && scl_fall) begin
        if (bit_cnt_q == 4'h8) begin
          // The control byte of a read is acked here; later read bytes are acked by the controller
          o_sda_oe <= lk.ack_en && (first_q || !lk.rd_mode);
        end else if (bit_cnt_q == 4'h9) begin
          bit_cnt_q <= 4'h0;
          first_q   <= 1'b0;
          tx_sh_q   <= {lk.tx_data[6:0], 1'b0};
          o_sda_oe  <= lk.rd_mode && !lk.tx_data[7];
        end else if (lk.rd_mode && bit_cnt_q != 4'h0) begin
          tx_sh_q  <= {tx_sh_q[6:0], 1'b0};
          o_sda_oe <= !tx_sh_q[7];
        end else begin
          o_sda_oe <= 1'b0;
        end
      end
    end
  end
endmodule : i2c_target_phy
`default_nettype wire

// file: rtl/eeprom_write_protect.sv
`timescale 1ns/10ps
`default_nettype none
`include "eeprom_guard_params.svh"
module eeprom_write_protect (
  input  wire logic        I_CLOCK,
  input  wire logic        I_RST_N,
  input  wire logic        I_SCL,
  input  wire logic        I_SDA,
  output logic             O_SDA,
  output logic             O_SDA_OE,
  output logic             O_GUARD_ENABLE,
  output logic [1:0]       O_GUARD_EXTENT,
  output logic             O_GUARD_FROZEN,
  output logic [15:0]      O_PAGE_GUARDED
);
  eeprom_guard_pkg::xfer_state_t state_q;
  logic [2:0]                    block_q;
  logic [7:0]                    addr_q;
  logic                          ack_q;
  logic                          rd_q;
  logic                          guard_enable;
  logic                          guard_extent_high;
  logic                          guard_extent_low;
  eeprom_guard_pkg::byte_t       config_guard_register;
  eeprom_guard_pkg::byte_t       nvm_guard_register;
  logic                          guard_freeze_bit;
  eeprom_guard_pkg::byte_t       mem_q [0:255];
  eeprom_guard_pkg::byte_t       rd_data;
  logic                          ctrl_match;
  logic                          wr_stb;
  logic                          reg_wr;
  logic                          ee_wr;

  i2c_link_if lk ();

  i2c_target_phy u_phy (
    .i_clk    (I_CLOCK),
    .i_rst_n  (I_RST_N),
    .i_scl    (I_SCL),
    .i_sda    (I_SDA),
    .o_sda_oe (O_SDA_OE),
    .lk       (lk.phy)
  );

  // Open-drain line: the pin only ever pulls low, so its driven level is fixed
  always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_SDA <= 1'b0;
    end else begin
      O_SDA <= 1'b0;
    end
  end

  // True when a page is inside the guarded extent
  function automatic logic page_guarded(input logic en, input logic [1:0] ext,
                                        input logic [3:0] page);
    page_guarded = en && (page[3:2] >= ~ext);
  endfunction : page_guarded

  assign ctrl_match = (lk.rx_byte[7:4] == `CTRL_CODE)
                   && ((lk.rx_byte[3:1] == `BLK_REG) || (lk.rx_byte[3:1] == `BLK_EEPROM));

  assign wr_stb = lk.rx_valid && (state_q == eeprom_guard_pkg::ST_DATA)
               && !lk.start && !lk.stop;
  assign reg_wr = wr_stb && (block_q == `BLK_REG);
  assign ee_wr  = wr_stb && (block_q == `BLK_EEPROM)
               && !page_guarded(guard_enable, {guard_extent_high, guard_extent_low},
                                addr_q[7:4]);

  assign lk.ack_en  = ack_q;
  assign lk.rd_mode = rd_q;
  assign lk.tx_data = rd_data;

  // Transfer sequencing
  always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      state_q <= eeprom_guard_pkg::ST_IDLE;
      block_q <= `BLK_REG;
      ack_q   <= 1'b0;
      rd_q    <= 1'b0;
    end else if (lk.start) begin
      state_q <= eeprom_guard_pkg::ST_CTRL;
      ack_q   <= 1'b0;
      rd_q    <= 1'b0;
    end else if (lk.stop) begin
      state_q <= eeprom_guard_pkg::ST_IDLE;
      ack_q   <= 1'b0;
      rd_q    <= 1'b0;
    end else if (lk.rx_valid) begin
      case (state_q)
        eeprom_guard_pkg::ST_CTRL: begin
          ack_q <= ctrl_match;
          if (ctrl_match) begin
            block_q <= lk.rx_byte[3:1];
            rd_q    <= lk.rx_byte[0];
            state_q <= lk.rx_byte[0] ? eeprom_guard_pkg::ST_READ : eeprom_guard_pkg::ST_WORD;
          end else begin
            state_q <= eeprom_guard_pkg::ST_IGNORE;
          end
        end
        eeprom_guard_pkg::ST_WORD: begin
          ack_q   <= 1'b1;
          state_q <= eeprom_guard_pkg::ST_DATA;
        end
        eeprom_guard_pkg::ST_DATA: begin
          ack_q <= 1'b1;
        end
        default: begin
          ack_q <= 1'b0;
        end
      endcase
    end
  end

  // Word address: set by the word byte, stepped by each data byte or acked read byte.
  // Kept across a repeated start so that a random read hits the address just sent.
  always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      addr_q <= 8'h00;
    end else if (lk.rx_valid && state_q == eeprom_guard_pkg::ST_WORD && !lk.start) begin
      addr_q <= lk.rx_byte;
    end else if (wr_stb && block_q == `BLK_EEPROM) begin
      // Page writes wrap inside their own 16-byte page
      addr_q <= {addr_q[7:4], addr_q[3:0] + 4'h1};
    end else if (wr_stb || lk.tx_ack) begin
      addr_q <= addr_q + 8'h01;
    end
  end

  // Guard register; frozen once the freeze bit is set
  always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      {guard_enable, guard_extent_high, guard_extent_low} <= `GUARD_RESET;
    end else if (reg_wr && addr_q == `ADDR_GUARD && !guard_freeze_bit) begin
      guard_enable      <= lk.rx_byte[`GUARD_EN_BIT];
      guard_extent_high <= lk.rx_byte[`GUARD_EXT_MSB];
      guard_extent_low  <= lk.rx_byte[`GUARD_EXT_LSB];
    end
  end

  // Sibling guard registers are held as plain storage; their meaning lives elsewhere
  always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      config_guard_register <= `SIBLING_RESET;
      nvm_guard_register    <= `SIBLING_RESET;
    end else if (reg_wr && !guard_freeze_bit) begin
      if (addr_q == `ADDR_CFG_GUARD) begin
        config_guard_register <= lk.rx_byte;
      end else if (addr_q == `ADDR_NVM_GUARD) begin
        nvm_guard_register <= lk.rx_byte;
      end
    end
  end

  // Freeze bit can only be set; nothing but reset clears it.
  // Limitation: a reset clears it too, since the nonvolatile copy is not modelled here.
  always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      guard_freeze_bit <= 1'b0;
    end else if (reg_wr && addr_q == `ADDR_FREEZE && lk.rx_byte[`FREEZE_BIT]) begin
      guard_freeze_bit <= 1'b1;
    end
  end

  // Emulated EEPROM array, erased state after reset
  always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      for (int i = 0; i < 256; i++) begin
        mem_q[i] <= `EEPROM_ERASED;
      end
    end else if (ee_wr) begin
      mem_q[addr_q] <= lk.rx_byte;
    end
  end

  // Read data for the byte about to be shifted out
  always_comb begin
    rd_data = 8'h00;
    if (block_q == `BLK_EEPROM) begin
      rd_data = mem_q[addr_q];
    end else if (addr_q == `ADDR_GUARD) begin
      rd_data = {5'h00, guard_enable, guard_extent_high, guard_extent_low};
    end else if (addr_q == `ADDR_CFG_GUARD) begin
      rd_data = config_guard_register;
    end else if (addr_q == `ADDR_NVM_GUARD) begin
      rd_data = nvm_guard_register;
    end else if (addr_q == `ADDR_FREEZE) begin
      rd_data = {7'h00, guard_freeze_bit};
    end
  end

  // Status outputs, registered
  always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_GUARD_ENABLE <= 1'b0;
      O_GUARD_EXTENT <= 2'h0;
    end else begin
      O_GUARD_ENABLE <= guard_enable;
      O_GUARD_EXTENT <= {guard_extent_high, guard_extent_low};
    end
  end

  // Freeze status, kept apart from the guard fields it locks
  always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_GUARD_FROZEN <= 1'b0;
    end else begin
      O_GUARD_FROZEN <= guard_freeze_bit;
    end
  end

  for (genvar p = 0; p < 16; p++) begin : g_page_map
    always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
      if (!I_RST_N) begin
        O_PAGE_GUARDED[p] <= 1'b0;
      end else begin
        O_PAGE_GUARDED[p] <= page_guarded(guard_enable, {guard_extent_high, guard_extent_low},
                                          4'(p));
      end
    end
  end
endmodule : eeprom_write_protect
`default_nettype wire

// file: tb/eeprom_guard_chk.sv
`timescale 1ns/10ps
`default_nettype none
module eeprom_guard_chk (
  input wire logic        I_CLOCK,
  input wire logic        I_RST_N,
  input wire logic        O_SDA,
  input wire logic        O_SDA_OE,
  input wire logic        O_GUARD_ENABLE,
  input wire logic [1:0]  O_GUARD_EXTENT,
  input wire logic        O_GUARD_FROZEN,
  input wire logic [15:0] O_PAGE_GUARDED
);
  default clocking @(posedge I_CLOCK); endclocking
  default disable iff (!I_RST_N);
  a_off_no_guard: assert property (!O_GUARD_ENABLE |-> O_PAGE_GUARDED == 16'h0000)
    else $error("pages guarded while disabled");
  a_quarter_pages: assert property (O_GUARD_ENABLE && O_GUARD_EXTENT == 2'h0
    |-> O_PAGE_GUARDED == 16'hF000) else $error("quarter extent wrong");
  a_half_pages: assert property (O_GUARD_ENABLE && O_GUARD_EXTENT == 2'h1
    |-> O_PAGE_GUARDED == 16'hFF00) else $error("half extent wrong");
  a_three_qtr: assert property (O_GUARD_ENABLE && O_GUARD_EXTENT == 2'h2
    |-> O_PAGE_GUARDED == 16'hFFF0) else $error("three quarter extent wrong");
  a_all_pages: assert property (O_GUARD_ENABLE && O_GUARD_EXTENT == 2'h3
    |-> O_PAGE_GUARDED == 16'hFFFF) else $error("full extent wrong");
  a_reset_clear: assert property ($rose(I_RST_N)
    |-> !O_GUARD_ENABLE && O_GUARD_EXTENT == 2'h0 && !O_GUARD_FROZEN) else $error("reset state");
  a_frozen_hold: assert property (O_GUARD_FROZEN
    |=> $stable(O_GUARD_ENABLE) && $stable(O_GUARD_EXTENT)) else $error("frozen guard moved");
  a_freeze_sticky: assert property (O_GUARD_FROZEN |=> O_GUARD_FROZEN)
    else $error("freeze bit dropped");
  a_sda_drain: assert property (O_SDA_OE |-> !O_SDA)
    else $error("sda driven high");
  a_oe_reset: assert property ($rose(I_RST_N) |-> !O_SDA_OE)
    else $error("sda pulled low after reset");
endmodule : eeprom_guard_chk
bind eeprom_write_protect eeprom_guard_chk u_chk (.I_CLOCK(I_CLOCK), .I_RST_N(I_RST_N),
  .O_SDA(O_SDA), .O_SDA_OE(O_SDA_OE), .O_GUARD_ENABLE(O_GUARD_ENABLE),
  .O_GUARD_EXTENT(O_GUARD_EXTENT), .O_GUARD_FROZEN(O_GUARD_FROZEN),
  .O_PAGE_GUARDED(O_PAGE_GUARDED));
`default_nettype wire

// file: tb/i2c_ctrl_model.sv
`timescale 1ns/10ps
`default_nettype none
module i2c_ctrl_model (
  input  wire logic i_clk,
  input  wire logic i_sda,
  output logic      o_scl,
  output logic      o_sda
);
  // Idle bus rests high on both lines, as the pull-ups leave it
  initial begin
    o_scl = 1'h1;
    o_sda = 1'h1;
  end
  // Half bit of 10 clocks keeps each SCL phase above the 8-clock minimum
  task automatic hp();
    repeat (10) @(posedge i_clk);
    #1;
  endtask : hp
  task automatic bitx(input logic b, output logic r);
    o_sda = b;
    hp();
    o_scl = 1'h1;
    hp();
    r = i_sda;
    o_scl = 1'h0;
  endtask : bitx
  task automatic start();
    o_sda = 1'h1;
    hp();
    o_scl = 1'h1;
    hp();
    o_sda = 1'h0;
    hp();
    o_scl = 1'h0;
  endtask : start
  task automatic stop();
    o_sda = 1'h0;
    hp();
    o_scl = 1'h1;
    hp();
    o_sda = 1'h1;
    hp();
  endtask : stop
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bitx(d[i], r);
    bitx(1'h1, r);
    ack = ~r;
  endtask : wbyte
  // Last byte of a read is refused so the device lets go of SDA
  task automatic rbyte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bitx(1'h1, d[i]);
    bitx(last, r);
  endtask : rbyte
endmodule : i2c_ctrl_model
`default_nettype wire

// file: tb/testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
  typedef struct packed {logic [7:0] wv; logic [15:0] pages;} row_t;
  logic                    clk, rst_n, scl, sda_c, sda_line, sda, oe, en, frz, ack;
  logic [1:0]              ext;
  logic [15:0]             pg;
  eeprom_guard_pkg::byte_t d;
  int                      err_total, check_count;
  row_t rows [8] = '{'{8'h00, 16'h0000}, '{8'h01, 16'h0000}, '{8'h02, 16'h0000},
    '{8'h03, 16'h0000}, '{8'h04, 16'hF000}, '{8'h05, 16'hFF00}, '{8'h06, 16'hFFF0},
    '{8'h07, 16'hFFFF}};
  assign sda_line = sda_c & ~oe;
  eeprom_write_protect u_dut (.I_CLOCK(clk), .I_RST_N(rst_n), .I_SCL(scl), .I_SDA(sda_line),
    .O_SDA(sda), .O_SDA_OE(oe), .O_GUARD_ENABLE(en), .O_GUARD_EXTENT(ext),
    .O_GUARD_FROZEN(frz), .O_PAGE_GUARDED(pg));
  i2c_ctrl_model u_ctl (.i_clk(clk), .i_sda(sda_line), .o_scl(scl), .o_sda(sda_c));
  task automatic end_sim();
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : end_sim
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [2:0] blk, input logic [7:0] a, input logic [7:0] v);
    logic a1, a2;
    u_ctl.start();
    u_ctl.wbyte({4'h1, blk, 1'h0}, ack);
    u_ctl.wbyte(a, a1);
    u_ctl.wbyte(v, a2);
    u_ctl.stop();
    chk({13'h0000, ack, a1, a2}, 16'h0007);
  endtask : wr
  task automatic rd(input logic [2:0] blk, input logic [7:0] a, output logic [7:0] v);
    logic a1, a2;
    u_ctl.start();
    u_ctl.wbyte({4'h1, blk, 1'h0}, a1);
    u_ctl.wbyte(a, a2);
    u_ctl.start();
    u_ctl.wbyte({4'h1, blk, 1'h1}, ack);
    chk({13'h0000, a1, a2, ack}, 16'h0007);
    u_ctl.rbyte(1'h1, v);
    u_ctl.stop();
  endtask : rd
  task automatic settle();
    repeat (4) @(posedge clk);
    #1;
  endtask : settle
  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end
  initial begin
    repeat (100000) @(posedge clk);
    err_total++;
    end_sim();
  end
  initial begin
    rst_n = 1'h0;
    err_total = 0;
    check_count = 0;
    repeat (6) @(posedge clk);
    #1 rst_n = 1'h1;
    settle();
    chk({12'h000, en, ext, frz}, 16'h0000);
    rd(3'h0, 8'hE2, d);
    chk(16'(d), 16'h0000);
    foreach (rows[i]) begin
      wr(3'h0, 8'hE2, rows[i].wv);
      settle();
      chk({13'h0000, en, ext}, {13'h0000, rows[i].wv[2:0]});
      chk(pg, rows[i].pages);
      rd(3'h0, 8'hE2, d);
      chk(16'(d), 16'(rows[i].wv));
    end
    foreach (rows[i]) if (i < 2) begin
      u_ctl.start();
      u_ctl.wbyte(i == 0 ? 8'h20 : 8'h12, ack);
      chk(16'(ack), 16'h0000);
      u_ctl.stop();
    end
    // Pages 0-3 stay open with extent 10, page 4 is the first guarded one
    wr(3'h0, 8'hE2, 8'h06);
    wr(3'h3, 8'h00, 8'h5A);
    wr(3'h3, 8'h40, 8'h33);
    rd(3'h3, 8'h00, d);
    chk(16'(d), 16'h005A);
    rd(3'h3, 8'h40, d);
    chk(16'(d), 16'h00FF);
    wr(3'h0, 8'hE0, 8'hA5);
    rd(3'h0, 8'hE0, d);
    chk(16'(d), 16'h00A5);
    wr(3'h0, 8'hE1, 8'h5C);
    rd(3'h0, 8'hE1, d);
    chk(16'(d), 16'h005C);
    wr(3'h0, 8'hE4, 8'h01);
    settle();
    chk(16'(frz), 16'h0001);
    wr(3'h0, 8'hE2, 8'h07);
    rd(3'h0, 8'hE2, d);
    chk(16'(d), 16'h0006);
    wr(3'h0, 8'hE0, 8'h3C);
    rd(3'h0, 8'hE0, d);
    chk(16'(d), 16'h00A5);
    wr(3'h0, 8'hE1, 8'h11);
    rd(3'h0, 8'hE1, d);
    chk(16'(d), 16'h005C);
    rst_n = 1'h0;
    settle();
    rst_n = 1'h1;
    settle();
    chk({12'h000, en, ext, frz}, 16'h0000);
    end_sim();
  end
endmodule : testbench
`default_nettype wire
